// >>> rtl/pmt_pkg.sv
// constants for the period match timer
// Behaviour
// RL1: timer is an 8-bit counter between a prescaler and a postscaler on match
// RL2: counter value is read/write and cleared by every reset
// RL3: counter runs from oscillator/4 through a 1, 4 or 16 prescaler
// RL4: counter counts up from zero and wraps to zero after matching period
// RL5: period register is read/write and resets to all ones
// RL6: each match feeds a 4-bit postscaler that sets flag bit 1
// RL7: clearing run enable stops counting, setting it resumes counting
// RL8: writing the counter value clears prescaler and postscaler counts
// RL9: writing the control register clears prescaler and postscaler counts
// RL10: every reset source clears prescaler and postscaler counts
// RL11: writing the control register leaves the counter value unchanged
// RL12: the match pulse before the postscaler is offered to the serial port
// RL13: postscale select n sets the flag once every n+1 matches
// RL14: prescale select 00 divides by 1, 01 by 4, 1x by 16
`default_nettype none
package pmt_pkg;
    localparam logic [7:0] PMT_ADDR_FLAGS   = 8'h0C;
    localparam logic [7:0] PMT_ADDR_ENABLES = 8'h8C;
    localparam logic [7:0] PMT_ADDR_COUNT   = 8'h10;
    localparam logic [7:0] PMT_ADDR_PERIOD  = 8'h14;
    localparam logic [7:0] PMT_ADDR_CTRL    = 8'h18;
    localparam logic [7:0] PMT_PERIOD_RST   = 8'hFF;
    localparam logic [7:0] PMT_ZERO8        = 8'h00;
    localparam logic [6:0] PMT_CTRL_MASK    = 7'h7F;
    localparam int         PMT_FLAG_BIT     = 1;
    localparam int         PMT_RUN_BIT      = 2;
    localparam int         PMT_POST_LSB     = 3;
    localparam int         PMT_POST_MSB     = 6;
    localparam logic [1:0] PMT_OSC_DIV_LAST = 2'h3;
    localparam logic [3:0] PMT_PRE_LAST_4   = 4'h3;
    localparam logic [3:0] PMT_PRE_LAST_16  = 4'hF;
    localparam logic [1:0] PMT_RESP_OKAY    = 2'h0;
    localparam logic [1:0] PMT_RESP_SLVERR  = 2'h2;
    typedef enum logic [1:0] {
        PMT_IDLE = 2'h0,
        PMT_RESP = 2'h1
    } pmt_wr_state_t;
endpackage
`default_nettype wire

// >>> rtl/pmt_timer.sv
// period match timer with an axi4-lite register slave
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`default_nettype none
module pmt_timer (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             match_tick,
    output logic             match_irq_flag
);
    import pmt_pkg::*;

    // decode of a write or read address into a register select
    function automatic logic [2:0] pmt_dec(input logic [7:0] a);
        pmt_dec = (a == PMT_ADDR_FLAGS)   ? 3'h1 :
                  (a == PMT_ADDR_ENABLES) ? 3'h2 :
                  (a == PMT_ADDR_COUNT)   ? 3'h3 :
                  (a == PMT_ADDR_PERIOD)  ? 3'h4 :
                  (a == PMT_ADDR_CTRL)    ? 3'h5 : 3'h0;
    endfunction

    logic [7:0] aw_addr_r;
    logic       aw_have_r;
    logic [7:0] w_data_r;
    logic       w_lane_r;
    logic       w_have_r;
    logic       bvalid_r;
    logic [1:0] bresp_r;
    logic       rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [7:0] count_r;
    logic [7:0] period_r;
    logic [6:0] ctrl_r;
    logic [7:0] flags_r;
    logic [7:0] enables_r;
    logic [1:0] osc_div_r;
    logic [3:0] pre_cnt_r;
    logic [3:0] post_cnt_r;
    logic       tick_r;

    // write and read channel bookkeeping
    wire        wr_go      = aw_have_r && w_have_r && !bvalid_r;
    wire [2:0]  wr_sel     = pmt_dec(aw_addr_r);
    wire        wr_en      = wr_go && w_lane_r;
    wire        wr_flags   = wr_en && (wr_sel == 3'h1);
    wire        wr_enables = wr_en && (wr_sel == 3'h2);
    wire        wr_count   = wr_en && (wr_sel == 3'h3);
    wire        wr_period  = wr_en && (wr_sel == 3'h4);
    wire        wr_ctrl    = wr_en && (wr_sel == 3'h5);
    wire        rd_go      = s_axi_arvalid && !rvalid_r;
    wire [2:0]  rd_sel     = pmt_dec(s_axi_araddr);

    // timer datapath: instruction clock, prescaler, compare, postscaler
    wire        run_enable       = ctrl_r[PMT_RUN_BIT];                           // RL7
    wire [1:0]  prescale_select  = ctrl_r[1:0];
    wire [3:0]  postscale_select = ctrl_r[PMT_POST_MSB:PMT_POST_LSB];
    wire        inst_tick        = (osc_div_r == PMT_OSC_DIV_LAST);               // RL3
    wire [3:0]  pre_last         = prescale_select[1] ? PMT_PRE_LAST_16 :       // RL14
                                   (prescale_select[0] ? PMT_PRE_LAST_4 : 4'h0);
    wire        scaler_clr       = wr_count || wr_ctrl;                           // RL8 RL9
    wire        pre_tick         = run_enable && inst_tick && (pre_cnt_r == pre_last);
    wire        is_match         = (count_r == period_r);
    wire        match_ev         = pre_tick && is_match && !scaler_clr;           // RL4
    wire        post_done        = match_ev && (post_cnt_r == postscale_select);  // RL13
    wire [7:0]  count_nxt        = wr_count ? w_data_r :                          // RL2
                                   (pre_tick ? (is_match ? PMT_ZERO8 : 8'(count_r + 8'h01)) : count_r);
    wire [7:0]  flags_sw         = wr_flags ? w_data_r : flags_r;
    wire [7:0]  flags_nxt        = flags_sw | (post_done ? 8'h02 : PMT_ZERO8); // RL6

    // read data selection
    wire [7:0]  rd_val = (rd_sel == 3'h1) ? flags_r :
                         (rd_sel == 3'h2) ? enables_r :
                         (rd_sel == 3'h3) ? count_r :
                         (rd_sel == 3'h4) ? period_r :
                         (rd_sel == 3'h5) ? {1'b0, ctrl_r} : PMT_ZERO8;

    // axi write address and data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_r <= PMT_ZERO8;
            aw_have_r <= 1'b0;
            w_data_r  <= PMT_ZERO8;
            w_lane_r  <= 1'b0;
            w_have_r  <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_r <= s_axi_awaddr;
                aw_have_r <= 1'b1;
            end else if (wr_go) begin
                aw_have_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_r <= s_axi_wdata[7:0];
                w_lane_r <= s_axi_wstrb[0];
                w_have_r <= 1'b1;
            end else if (wr_go) begin
                w_have_r <= 1'b0;
            end
        end
    end

    // axi write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= PMT_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= (wr_sel == 3'h0) ? PMT_RESP_SLVERR : PMT_RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // axi read channel, one cycle answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= PMT_RESP_OKAY;
        end else if (rd_go) begin
            rvalid_r <= 1'b1;
            rdata_r  <= {24'h00_0000, rd_val};
            rresp_r  <= (rd_sel == 3'h0) ? PMT_RESP_SLVERR : PMT_RESP_OKAY;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // software registers; a control write keeps the count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            period_r  <= PMT_PERIOD_RST;   // RL5
            ctrl_r    <= 7'h00;
            enables_r <= PMT_ZERO8;
            flags_r   <= PMT_ZERO8;
        end else begin
            if (wr_period)
                period_r <= w_data_r;      // RL5
            if (wr_ctrl)
                ctrl_r <= w_data_r[6:0] & PMT_CTRL_MASK; // RL11
            if (wr_enables)
                enables_r <= w_data_r;
            flags_r <= flags_nxt;          // set wins over clear
        end
    end

    // counter and scaler counts
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_r    <= PMT_ZERO8;       // RL2
            osc_div_r  <= 2'h0;
            pre_cnt_r  <= 4'h0;            // RL10
            post_cnt_r <= 4'h0;            // RL10
            tick_r     <= 1'b0;
        end else begin
            count_r   <= count_nxt;        // RL1
            osc_div_r <= 2'(osc_div_r + 2'h1);
            tick_r    <= match_ev;         // RL12
            if (scaler_clr) begin
                pre_cnt_r  <= 4'h0;        // RL8 RL9
                post_cnt_r <= 4'h0;
            end else begin
                if (run_enable && inst_tick)
                    pre_cnt_r <= pre_tick ? 4'h0 : 4'(pre_cnt_r + 4'h1);
                if (match_ev)
                    post_cnt_r <= post_done ? 4'h0 : 4'(post_cnt_r + 4'h1); // RL6
            end
        end
    end

    // bus handshake outputs, all registered
    assign s_axi_awready  = !aw_have_r;
    assign s_axi_wready   = !w_have_r;
    assign s_axi_bvalid   = bvalid_r;
    assign s_axi_bresp    = bresp_r;
    assign s_axi_arready  = !rvalid_r;
    assign s_axi_rvalid   = rvalid_r;
    assign s_axi_rdata    = rdata_r;
    assign s_axi_rresp    = rresp_r;
    assign match_tick     = tick_r;
    assign match_irq_flag = flags_r[PMT_FLAG_BIT];
endmodule
`default_nettype wire

// >>> test/pmt_timer_chk.sv
// port assertions for the period match timer
`default_nettype none
module pmt_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        match_tick,
    input wire logic        match_irq_flag
);
    // all checks on the bus clock, off during reset
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence quiet3;
        !match_tick [*3];
    endsequence
    a_read_answer: assert property (rd_take |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answer pending");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped or changed");
    a_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer kept after taken");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped or changed");
    a_byte_lane: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data above byte lane");
    a_tick_gap: assert property (match_tick |=> quiet3)
        else $error("match ticks closer than four cycles");
    a_flag_tick: assert property ($rose(match_irq_flag) && !$rose(s_axi_bvalid) |-> ##[0:1] match_tick)
        else $error("flag set without a match");
endmodule
bind pmt_timer pmt_chk u_pmt_chk (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .match_tick, .match_irq_flag);
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench for the period match timer
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import pmt_pkg::*;
    localparam logic [1:0] OK = PMT_RESP_OKAY;
    localparam logic [1:0] ER = PMT_RESP_SLVERR;
    logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid, tick, flag;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [3:0]  wstrb = 4'hF;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0]  bresp, rresp;
    int          failures = 0, n_compared = 0, cyc = 0, nt = 0;
    pmt_timer u_pmt_timer (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .match_tick(tick),
        .match_irq_flag(flag));
    // clock, cycle and tick counters, hang limit
    always #25 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        nt <= nt + ((tick === 1'b1) ? 1 : 0);
        if (cyc == 6000) begin
            failures++;
            summarize();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // bus write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ad, dd;
        {ad, dd} = 2'h0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        while (!(ad && dd)) begin
            @(posedge aclk);
            if (awready && !ad) awvalid <= 1'b0;
            if (wready && !dd) wvalid <= 1'b0;
            ad |= awready;
            dd |= wready;
        end
        while (!bvalid) @(posedge aclk);
        chk("bresp", 32'(er), 32'(bresp));
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge aclk);
        chk("rdata", e, rdata);
        chk("rresp", 32'(er), 32'(rresp));
        rready <= 1'b0;
    endtask
    // reset values, readback and unmapped places
    task automatic t_regs();
        rd(PMT_ADDR_FLAGS, 32'h0, OK);
        rd(PMT_ADDR_COUNT, 32'h0, OK);
        rd(PMT_ADDR_PERIOD, 32'hFF, OK);
        rd(PMT_ADDR_CTRL, 32'h0, OK);
        rd(PMT_ADDR_ENABLES, 32'h0, OK);
        rd(8'h04, 32'h0, ER);
        wr(8'h04, 32'h55, ER);
        wr(PMT_ADDR_ENABLES, 32'hA5A5, OK);
        rd(PMT_ADDR_ENABLES, 32'hA5, OK);
        wr(PMT_ADDR_PERIOD, 32'h3C, OK);
        rd(PMT_ADDR_PERIOD, 32'h3C, OK);
    endtask
    // stopped timer holds its count; control write keeps it
    task automatic t_hold();
        wr(PMT_ADDR_COUNT, 32'h05, OK);
        repeat (40) @(posedge aclk);
        rd(PMT_ADDR_COUNT, 32'h05, OK);
        wr(PMT_ADDR_CTRL, 32'hFB, OK);
        rd(PMT_ADDR_COUNT, 32'h05, OK);
        rd(PMT_ADDR_CTRL, 32'h7B, OK);
    endtask
    // start from a clean count, wait for the flag, report cycles and ticks
    task automatic run(input logic [7:0] c, output int dc, output int dt);
        wr(PMT_ADDR_CTRL, 32'h0, OK);
        wr(PMT_ADDR_FLAGS, 32'h0, OK);
        wr(PMT_ADDR_COUNT, 32'h0, OK);
        wr(PMT_ADDR_CTRL, {24'h0, c}, OK);
        dc = cyc;
        dt = nt;
        while (flag !== 1'b1) @(posedge aclk);
        repeat (2) @(posedge aclk);
        dc = cyc - dc - 2;
        dt = nt - dt;
    endtask
    task automatic t_pre();
        int dc, dt, dv;
        wr(PMT_ADDR_PERIOD, 32'h07, OK);
        for (int ps = 0; ps < 4; ps++) begin
            dv = (ps == 0) ? 1 : (ps == 1) ? 4 : 16;
            run(8'(4 + ps), dc, dt);
            chk("cycles", 32'(dc >= 32 * dv - 6 && dc <= 32 * dv + 2), 32'h1);
            chk("ticks", 32'(dt), 32'h1);
        end
    endtask
    task automatic t_post();
        int dc, dt;
        wr(PMT_ADDR_PERIOD, 32'h00, OK);
        for (int n = 0; n < 16; n += 5) begin
            run(8'(4 + n * 8), dc, dt);
            chk("post ticks", 32'(dt), 32'(n + 1));
        end
    endtask
    // reset in mid-run while counting: count, period and control go back to reset values
    task automatic t_rst();
        wr(PMT_ADDR_PERIOD, 32'h20, OK);
        wr(PMT_ADDR_CTRL, 32'h04, OK);
        repeat (20) @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(PMT_ADDR_COUNT, 32'h0, OK);
        rd(PMT_ADDR_PERIOD, 32'hFF, OK);
        rd(PMT_ADDR_CTRL, 32'h0, OK);
        chk("flag", 32'h0, 32'(flag));
    endtask
    task automatic summarize();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // reset for three cycles, then the scenarios
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_hold();
        t_pre();
        t_post();
        t_rst();
        summarize();
    end
endmodule
`default_nettype wire
